// ---- src/tws_cfg.svh ----
// Constants for the two-wire configuration slave
`ifndef TWS_CFG_SVH
`define TWS_CFG_SVH

// Command codes
`define TWS_CMD_DIV     8'h01
`define TWS_CMD_MUX     8'h02
`define TWS_CMD_BUS     8'h0d
`define TWS_CMD_COMMIT  8'h3f

// Reset values of the configuration words
`define TWS_DIV_RST     10'h000
`define TWS_MUX_RST     16'h1800
`define TWS_BUS_RST     8'h00

// Bus word fields
`define TWS_BUS_SEL_MSB 2
`define TWS_BUS_WC_POS  3

// Timing
`define TWS_SYS_CLK_HZ  20000000
`define TWS_NV_WRITE_US 10000
`define TWS_NV_WRITE_CYC ((`TWS_NV_WRITE_US) * (`TWS_SYS_CLK_HZ / 1000000))

`endif

// ---- src/tws_pkg.sv ----
// Types for the two-wire configuration slave
package tws_pkg;

	typedef enum logic [3:0] {
		TWS_IDLE      = 4'b0000,
		TWS_ADDR      = 4'b0001,
		TWS_ADDR_ACK  = 4'b0010,
		TWS_CMD       = 4'b0011,
		TWS_CMD_ACK   = 4'b0100,
		TWS_WDATA     = 4'b0101,
		TWS_WDATA_ACK = 4'b0110,
		TWS_RDATA     = 4'b0111,
		TWS_RDATA_ACK = 4'b1000,
		TWS_IGNORE    = 4'b1001
	} tws_state_t;

endpackage

// ---- src/tws_slave.sv ----
// Two-wire configuration slave with nonvolatile commit control
//
// Summary of operation
// - Idle only with both lines high
// - SDA fall with SCL high starts transfer
// - SDA rise with SCL high stops, idle
// - SDA changes only while SCL low
// - Bytes MSB first, ninth clock acknowledges
// - Works at 100kHz and 400kHz
// - Ack drives SDA low across ack high
// - Nack everything during nonvolatile write
// - Master nack on read releases SDA
// - Repeated start accepts a new control byte
// - Control byte: code, select bits, direction
// - Ack only on code and select match
// - Direction one reads, zero writes
// - Ack control, command and data bytes
// - Command 01 selects divider word
// - Command 02 selects output select word
// - Command 0D selects bus configuration word
// - Write control zero commits each write
// - Write control one commits on 3F
// - Bus word write commits immediately always
// - Divider ten bits, high byte first
// - Bus word: control bit, selects, reserved zero
// - Refuse programming in power-down
`include "tws_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module tws_slave
	import tws_pkg::*;
#(
	parameter int unsigned NV_WRITE_CYC = `TWS_NV_WRITE_CYC,
	parameter logic [3:0]  TYPE_CODE    = 4'ha // Arbitrary value
) (
	input  wire logic        sys_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        link_clk_i,
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output var  logic        sda_o,
	output var  logic        sda_oe_o,
	input  wire logic        power_down_i,
	output var  logic [9:0]  div_word_o,
	output var  logic [15:0] output_select_word_o,
	output var  logic [7:0]  bus_word_o,
	output var  logic        nv_commit_o,
	output var  logic        nv_busy_o
);

	// ------------------------------------------------------------
	// Link domain reset and input synchronisers
	// ------------------------------------------------------------
	logic       lrst_m;
	logic       lrst_n;
	logic [1:0] scl_m;
	logic [1:0] sda_m;
	logic       scl_s;
	logic       sda_s;
	logic       scl_q;
	logic       sda_q;
	logic       busy_m;
	logic       busy_s;
	logic       pd_m;
	logic       pd_s;

	// Async assert, release synchronised to the link clock
	always_ff @(posedge link_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lrst_m <= 1'b0;
			lrst_n <= 1'b0;
		end else begin
			lrst_m <= 1'b1;
			lrst_n <= lrst_m;
		end
	end

	// Oversampling far above 400kHz keeps both bus rates safe
	always_ff @(posedge link_clk_i or negedge lrst_n) begin
		if (!lrst_n) begin
			scl_m  <= 2'h3;
			sda_m  <= 2'h3;
			scl_q  <= 1'b1;
			sda_q  <= 1'b1;
			busy_m <= 1'b0;
			busy_s <= 1'b0;
			pd_m   <= 1'b0;
			pd_s   <= 1'b0;
		end else begin
			scl_m  <= {scl_m[0], scl_i};
			sda_m  <= {sda_m[0], sda_i};
			scl_q  <= scl_m[1];
			sda_q  <= sda_m[1];
			busy_m <= nv_busy_o;
			busy_s <= busy_m;
			pd_m   <= power_down_i;
			pd_s   <= pd_m;
		end
	end

	assign scl_s = scl_m[1];
	assign sda_s = sda_m[1];

	// ------------------------------------------------------------
	// Bus condition detection
	// ------------------------------------------------------------
	logic start_det;
	logic stop_det;
	logic scl_rise;
	logic scl_fall;
	logic refuse;

	// SDA moving while SCL high is a condition, never data
	assign start_det = scl_s && scl_q && sda_q && !sda_s;
	assign stop_det  = scl_s && scl_q && !sda_q && sda_s;
	assign scl_rise  = scl_s && !scl_q;
	assign scl_fall  = !scl_s && scl_q;
	assign refuse    = busy_s || pd_s;

	// ------------------------------------------------------------
	// Protocol state
	// ------------------------------------------------------------
	tws_state_t state;
	logic [7:0] shreg;
	logic [2:0] bit_cnt;
	logic       got8;
	logic       rd_mode;
	logic       byte_idx;
	logic       mst_ack;
	logic [7:0] cmd;
	logic       pend_commit;
	logic       commit_tgl;
	logic       upd_tgl;
	logic       oe;
	logic [9:0] div_l;
	logic [15:0] mux_l;
	logic [7:0] bus_l;

	logic       byte_end;
	logic       addr_ok;
	logic       cmd_ok;
	logic       wr_now;
	logic       wc;
	logic       idx_after;
	logic [7:0] rd_byte_cur;
	logic [7:0] rd_byte_nxt;

	assign wc       = bus_l[`TWS_BUS_WC_POS];
	assign byte_end = scl_fall && got8;
	// Control byte: type code, select bits, direction
	assign addr_ok  = (shreg[7:4] == TYPE_CODE) &&
		(shreg[3:1] == bus_l[`TWS_BUS_SEL_MSB:0]);
	assign cmd_ok   = (shreg == `TWS_CMD_DIV) || (shreg == `TWS_CMD_MUX) ||
		(shreg == `TWS_CMD_BUS) || (shreg == `TWS_CMD_COMMIT);
	assign wr_now   = (state == TWS_WDATA) && byte_end && !refuse;

	// Outgoing byte for the selected word and byte index
	function automatic logic [7:0] tws_rd_byte(input logic [7:0] c, input logic idx,
		input logic [9:0] dv, input logic [15:0] mx, input logic [7:0] bs);
		logic [7:0] r;
		r = 8'h00;
		case (c)
			`TWS_CMD_DIV: r = idx ? {dv[1:0], 6'h00} : dv[9:2];
			`TWS_CMD_MUX: r = idx ? mx[7:0] : mx[15:8];
			`TWS_CMD_BUS: r = bs;
			default:      r = 8'h00;
		endcase
		return r;
	endfunction

	// Byte loaded after the master's ack must use the advanced index
	assign idx_after   = !byte_idx && (cmd != `TWS_CMD_BUS);
	assign rd_byte_cur = tws_rd_byte(cmd, byte_idx, div_l, mux_l, bus_l);
	assign rd_byte_nxt = tws_rd_byte(cmd, idx_after, div_l, mux_l, bus_l);

	// Bit counting and shifting, MSB first
	always_ff @(posedge link_clk_i or negedge lrst_n) begin
		if (!lrst_n) begin
			shreg   <= 8'h00;
			bit_cnt <= 3'h0;
			got8    <= 1'b0;
		end else if (start_det || stop_det) begin
			bit_cnt <= 3'h0;
			got8    <= 1'b0;
		end else if (state == TWS_RDATA) begin
			if (scl_rise) begin
				bit_cnt <= bit_cnt + 3'h1;
			end
			if (scl_fall) begin
				shreg <= {shreg[6:0], 1'b0};
			end
		end else if ((state == TWS_ADDR_ACK || state == TWS_RDATA_ACK) && scl_fall &&
			(rd_mode && (state == TWS_RDATA_ACK ? mst_ack : 1'b1))) begin
			shreg   <= (state == TWS_RDATA_ACK) ? rd_byte_nxt : rd_byte_cur;
			bit_cnt <= 3'h0;
		end else if (state == TWS_ADDR || state == TWS_CMD || state == TWS_WDATA) begin
			if (scl_rise) begin
				shreg   <= {shreg[6:0], sda_s};
				bit_cnt <= bit_cnt + 3'h1;
				got8    <= (bit_cnt == 3'h7);
			end else if (byte_end) begin
				got8 <= 1'b0;
			end
		end else begin
			got8    <= 1'b0;
			bit_cnt <= 3'h0;
		end
	end

	// Main sequence
	always_ff @(posedge link_clk_i or negedge lrst_n) begin
		if (!lrst_n) begin
			state    <= TWS_IDLE;
			rd_mode  <= 1'b0;
			byte_idx <= 1'b0;
			mst_ack  <= 1'b0;
			cmd      <= 8'h00;
		end else if (start_det) begin
			state    <= TWS_ADDR;
			byte_idx <= 1'b0;
		end else if (stop_det) begin
			state <= TWS_IDLE;
		end else begin
			case (state)
				TWS_IDLE: begin
					state <= TWS_IDLE;
				end
				TWS_ADDR: begin
					if (byte_end) begin
						rd_mode <= shreg[0];
						state   <= TWS_ADDR_ACK;
					end
				end
				TWS_ADDR_ACK: begin
					if (scl_fall) begin
						if (!oe) begin
							state <= TWS_IGNORE;
						end else if (rd_mode) begin
							state <= TWS_RDATA;
						end else begin
							state <= TWS_CMD;
						end
					end
				end
				TWS_CMD: begin
					if (byte_end) begin
						if (!refuse && cmd_ok) begin
							cmd <= shreg;
						end
						state <= TWS_CMD_ACK;
					end
				end
				TWS_CMD_ACK: begin
					if (scl_fall) begin
						state <= oe ? TWS_WDATA : TWS_IGNORE;
					end
				end
				TWS_WDATA: begin
					if (byte_end) begin
						state <= TWS_WDATA_ACK;
					end
				end
				TWS_WDATA_ACK: begin
					if (scl_fall) begin
						byte_idx <= (cmd == `TWS_CMD_BUS) ? 1'b0 : !byte_idx;
						state    <= oe ? TWS_WDATA : TWS_IGNORE;
					end
				end
				TWS_RDATA: begin
					if (scl_fall && bit_cnt == 3'h0) begin
						state <= TWS_RDATA_ACK;
					end
				end
				TWS_RDATA_ACK: begin
					if (scl_rise) begin
						mst_ack <= !sda_s;
					end
					if (scl_fall) begin
						byte_idx <= (cmd == `TWS_CMD_BUS) ? 1'b0 : !byte_idx;
						state    <= mst_ack ? TWS_RDATA : TWS_IGNORE;
					end
				end
				TWS_IGNORE: begin
					state <= TWS_IGNORE;
				end
				default: begin
					state <= TWS_IDLE;
				end
			endcase
		end
	end

	// SDA drive: changes only on SCL fall
	always_ff @(posedge link_clk_i or negedge lrst_n) begin
		if (!lrst_n) begin
			oe <= 1'b0;
		end else if (start_det || stop_det) begin
			oe <= 1'b0;
		end else if (scl_fall) begin
			case (state)
				TWS_ADDR: begin
					oe <= got8 && addr_ok && !refuse;
				end
				TWS_CMD: begin
					oe <= got8 && cmd_ok && !refuse;
				end
				TWS_WDATA: begin
					oe <= got8 && !refuse;
				end
				TWS_ADDR_ACK: begin
					oe <= rd_mode && oe && !rd_byte_cur[7];
				end
				TWS_RDATA: begin
					oe <= (bit_cnt != 3'h0) && !shreg[6];
				end
				TWS_RDATA_ACK: begin
					oe <= mst_ack && !rd_byte_nxt[7];
				end
				default: begin
					oe <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge link_clk_i or negedge lrst_n) begin
		if (!lrst_n) begin
			sda_oe_o <= 1'b0;
			sda_o    <= 1'b0;
		end else begin
			sda_oe_o <= oe;
			sda_o    <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Live configuration words
	// ------------------------------------------------------------
	always_ff @(posedge link_clk_i or negedge lrst_n) begin
		if (!lrst_n) begin
			div_l <= `TWS_DIV_RST;
			mux_l <= `TWS_MUX_RST;
			bus_l <= `TWS_BUS_RST;
		end else if (wr_now) begin
			case (cmd)
				`TWS_CMD_DIV: begin
					if (byte_idx) begin
						div_l[1:0] <= shreg[7:6];
					end else begin
						div_l[9:2] <= shreg;
					end
				end
				`TWS_CMD_MUX: begin
					if (byte_idx) begin
						mux_l[7:0] <= shreg;
					end else begin
						mux_l[15:8] <= shreg;
					end
				end
				`TWS_CMD_BUS: begin
					bus_l <= {4'h0, shreg[3:0]};
				end
				default: begin
					bus_l <= bus_l;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Commit and update requests toward the system domain
	// ------------------------------------------------------------
	always_ff @(posedge link_clk_i or negedge lrst_n) begin
		if (!lrst_n) begin
			pend_commit <= 1'b0;
			commit_tgl  <= 1'b0;
			upd_tgl     <= 1'b0;
		end else begin
			if (wr_now) begin
				upd_tgl <= !upd_tgl;
			end
			if (wr_now && cmd == `TWS_CMD_BUS) begin
				commit_tgl  <= !commit_tgl;
				pend_commit <= 1'b0;
			end else if (start_det || stop_det) begin
				// Command ends at stop or repeated start
				if (pend_commit) begin
					commit_tgl <= !commit_tgl;
				end
				pend_commit <= 1'b0;
			end else if (wr_now && !wc) begin
				pend_commit <= 1'b1;
			end else if (state == TWS_CMD && byte_end && !refuse &&
				shreg == `TWS_CMD_COMMIT) begin
				pend_commit <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// System domain: word capture and nonvolatile write timer
	// ------------------------------------------------------------
	logic [2:0]  upd_sy;
	logic [2:0]  com_sy;
	logic [17:0] nv_cnt;

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			upd_sy <= 3'h0;
			com_sy <= 3'h0;
		end else begin
			upd_sy <= {upd_sy[1:0], upd_tgl};
			com_sy <= {com_sy[1:0], commit_tgl};
		end
	end

	// Link words sit still for a whole byte, far longer than the sync
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			div_word_o           <= `TWS_DIV_RST;
			output_select_word_o <= `TWS_MUX_RST;
			bus_word_o           <= `TWS_BUS_RST;
		end else if ((upd_sy[2] ^ upd_sy[1]) || (com_sy[2] ^ com_sy[1])) begin
			div_word_o           <= div_l;
			output_select_word_o <= mux_l;
			bus_word_o           <= bus_l;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			nv_cnt      <= 18'h00000;
			nv_busy_o   <= 1'b0;
			nv_commit_o <= 1'b0;
		end else begin
			nv_commit_o <= com_sy[2] ^ com_sy[1];
			if (com_sy[2] ^ com_sy[1]) begin
				nv_cnt    <= 18'(NV_WRITE_CYC - 1);
				nv_busy_o <= 1'b1;
			end else if (nv_cnt != 18'h00000) begin
				nv_cnt <= nv_cnt - 18'h00001;
			end else begin
				nv_busy_o <= 1'b0;
			end
		end
	end

endmodule // tws_slave

`default_nettype wire

// ---- tb/two_wire_config_slave_tb_top.sv ----
// Self-checking bench for the two-wire configuration slave
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fail_count++; \
	$display("ERROR %0t got %h exp %h", $time, (a), (e)); end end
module two_wire_config_slave_tb_top;
	localparam int NV = 2000;
	typedef struct packed {
		logic [7:0]  cmd;
		logic [7:0]  b0;
		logic [7:0]  b1;
		logic [1:0]  n;
		logic [15:0] word;
	} tws_row_t;
	tws_row_t   rows [5] = '{'{8'h01, 8'ha5, 8'hc0, 2'd2, 16'h0297}, '{8'h02, 8'h3c, 8'h5a, 2'd2, 16'h3c5a},
		'{8'h02, 8'hff, 8'hff, 2'd2, 16'hffff}, '{8'h01, 8'h00, 8'h7f, 2'd2, 16'h0001},
		'{8'h0d, 8'hf5, 8'h00, 2'd1, 16'h0005}};
	logic       clk, lclk, rst_n, pd, scl, sda_m, sda_oe, sda_d, commit, busy, ack;
	logic [9:0] div;
	logic [15:0] osw, er;
	logic [7:0] bus, rd;
	logic [2:0] sel;
	int         fail_count, n_compared, commits, c0;
	wire        sda = sda_m & (sda_oe ? sda_d : 1'b1);
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		lclk = 1'b0;
		#1.7;
		forever #3 lclk = ~lclk;
	end
	always @(posedge clk) if (commit === 1'b1) commits++;
	tws_slave #(.NV_WRITE_CYC(NV)) dut_u (.sys_clk_i(clk), .rst_n_i(rst_n), .link_clk_i(lclk), .scl_i(scl),
		.sda_i(sda), .sda_o(sda_d), .sda_oe_o(sda_oe), .power_down_i(pd), .div_word_o(div),
		.output_select_word_o(osw), .bus_word_o(bus), .nv_commit_o(commit), .nv_busy_o(busy));
	tws_master m_u (.sys_clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(sda_m));
	task automatic report_and_stop();
		$display("compared %0d failed %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic send(input logic [7:0] d, input logic a);
		m_u.xfer(d, 1'b1, rd, ack);
		`CHK(ack, a)
	endtask
	task automatic wr(input logic [7:0] c, b0, b1, input int n);
		m_u.start();
		send({4'ha, sel, 1'b0}, 1'b0);
		send(c, 1'b0);
		for (int k = 0; k < n; k++) send(k ? b1 : b0, 1'b0);
		m_u.stop();
	endtask
	function automatic logic [15:0] cur(input logic [7:0] c);
		return c == 8'h01 ? {6'h00, div} : c == 8'h0d ? {8'h00, bus} : osw;
	endfunction
	// Divider low bits come back at the top of the second byte
	function automatic logic [15:0] exp_rd(input logic [7:0] c, input logic [15:0] w);
		return c == 8'h01 ? {w[9:2], w[1:0], 6'h00} : c == 8'h0d ? {w[7:0], w[7:0]} : w;
	endfunction
	initial begin
		repeat (90000) @(posedge clk);
		fail_count++;
		report_and_stop();
	end
	initial begin
		rst_n = 1'b0;
		pd = 1'b0;
		sel = 3'h0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		`CHK(cur(8'h01), 16'h0000)
		`CHK(osw, 16'h1800)
		`CHK(bus, 8'h00)
		`CHK(busy, 1'b0)
		`CHK(sda_oe, 1'b0)
		`CHK(sda_d, 1'b0)
		foreach (rows[i]) begin
			c0 = commits;
			wr(rows[i].cmd, rows[i].b0, rows[i].b1, rows[i].n);
			repeat (NV + 20) @(posedge clk);
			`CHK(commits != c0, 1'b1)
			`CHK(cur(rows[i].cmd), rows[i].word)
			if (rows[i].cmd == 8'h0d) sel = rows[i].word[2:0];
			er = exp_rd(rows[i].cmd, rows[i].word);
			m_u.start();
			send({4'ha, sel, 1'b0}, 1'b0);
			send(rows[i].cmd, 1'b0);
			m_u.start();
			send({4'ha, sel, 1'b1}, 1'b0);
			m_u.xfer(8'hff, 1'b0, rd, ack);
			`CHK(rd, er[15:8])
			m_u.xfer(8'hff, 1'b1, rd, ack);
			`CHK(rd, er[7:0])
			m_u.stop();
		end
		// Refusals stay released until the next start
		m_u.start();
		send({4'ha, ~sel, 1'b0}, 1'b1);
		send(8'h01, 1'b1);
		m_u.start();
		send({4'h5, sel, 1'b0}, 1'b1);
		m_u.start();
		send({4'ha, sel, 1'b0}, 1'b0);
		send(8'h07, 1'b1);
		m_u.stop();
		pd <= 1'b1;
		m_u.start();
		send({4'ha, sel, 1'b0}, 1'b1);
		m_u.stop();
		pd <= 1'b0;
		c0 = commits;
		wr(8'h0d, {4'h0, 1'b1, sel}, 8'h00, 1);
		repeat (NV + 20) @(posedge clk);
		`CHK(commits != c0, 1'b1)
		`CHK(bus, {4'h0, 1'b1, sel})
		c0 = commits;
		wr(8'h01, 8'h12, 8'h00, 2);
		repeat (40) @(posedge clk);
		`CHK(commits, c0)
		`CHK(div, 10'h048)
		wr(8'h3f, 8'h00, 8'h00, 0);
		repeat (40) @(posedge clk);
		`CHK(commits != c0, 1'b1)
		m_u.start();
		send({4'ha, sel, 1'b0}, 1'b1);
		m_u.stop();
		repeat (NV) @(posedge clk);
		wr(8'h02, 8'h11, 8'h22, 2);
		repeat (10) @(posedge clk);
		`CHK(osw, 16'h1122)
		report_and_stop();
	end
endmodule // two_wire_config_slave_tb_top
bind tws_slave tws_slave_sva #(.NV_WRITE_CYC(NV_WRITE_CYC)) sva_u (.sys_clk_i, .rst_n_i, .link_clk_i, .scl_i,
	.sda_i, .sda_o, .sda_oe_o, .power_down_i, .div_word_o, .output_select_word_o, .bus_word_o, .nv_commit_o,
	.nv_busy_o);
`default_nettype wire

// ---- tb/tws_master.sv ----
// Behavioural bus master that drives the slave's clock and data lines
`timescale 1ns/1ps
`default_nettype none
module tws_master (
	input  wire logic sys_clk_i,
	input  wire logic sda_i,
	output var  logic scl_o,
	output var  logic sda_o
);
	// ------
	// Bit timing
	// ------
	// Quarter bit of 13 cycles: 2.6 us per bit, just under the fast-mode rate
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic q();
		repeat (13) @(posedge sys_clk_i);
	endtask
	// Only begins from idle or from a finished byte
	task automatic start();
		sda_o <= 1'b1;
		q();
		scl_o <= 1'b1;
		q();
		sda_o <= 1'b0;
		q();
		scl_o <= 1'b0;
		q();
	endtask
	task automatic stop();
		sda_o <= 1'b0;
		q();
		scl_o <= 1'b1;
		q();
		sda_o <= 1'b1;
		q();
	endtask
	task automatic bit_x(input logic b, output logic r);
		sda_o <= b;
		q();
		scl_o <= 1'b1;
		q();
		r = sda_i;
		q();
		scl_o <= 1'b0;
		q();
	endtask
	// Writes pass a released ack; reads release it only on the last byte
	task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] r, output logic ack);
		for (int i = 7; i >= 0; i--) bit_x(d[i], r[i]);
		bit_x(a, ack);
	endtask
endmodule // tws_master
`default_nettype wire

// ---- tb/tws_slave_sva.sv ----
// Port-level assertions for the two-wire configuration slave
`timescale 1ns/1ps
`default_nettype none
module tws_slave_sva #(
	parameter int unsigned NV_WRITE_CYC = 20
) (
	input wire logic        sys_clk_i,
	input wire logic        rst_n_i,
	input wire logic        link_clk_i,
	input wire logic        scl_i,
	input wire logic        sda_i,
	input wire logic        sda_o,
	input wire logic        sda_oe_o,
	input wire logic        power_down_i,
	input wire logic [9:0]  div_word_o,
	input wire logic [15:0] output_select_word_o,
	input wire logic [7:0]  bus_word_o,
	input wire logic        nv_commit_o,
	input wire logic        nv_busy_o
);
	int unsigned busy_len;
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			busy_len <= 0;
		end else begin
			busy_len <= nv_busy_o ? busy_len + 1 : 0;
		end
	end
	// ------
	// Link side
	// ------
	oe_scl_low_a: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
		$changed(sda_oe_o) |-> !scl_i) else $error("sda enable moved with scl high");
	ack_hold_a: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
		$rose(scl_i) && sda_oe_o |=> sda_oe_o [*8]) else $error("ack dropped in high phase");
	// ------
	// System side
	// ------
	reserved_zero_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		bus_word_o[7:4] == 4'h0) else $error("bus word reserved bits set");
	commit_pulse_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		nv_commit_o |=> !nv_commit_o) else $error("commit longer than a cycle");
	commit_busy_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		nv_commit_o |-> ##[0:2] nv_busy_o) else $error("commit without busy");
	// A second commit may stretch busy, so only a short stretch is wrong
	busy_len_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		$fell(nv_busy_o) |-> busy_len >= NV_WRITE_CYC) else $error("busy too short");
	busy_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		nv_busy_o |=> $stable(div_word_o) && $stable(output_select_word_o)) else $error("word changed while busy");
	pd_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		power_down_i |=> $stable(div_word_o) && $stable(bus_word_o)) else $error("word changed in power-down");
endmodule // tws_slave_sva
`default_nettype wire
